// ==== pkg/vst_pkg.sv ====
// shared constants for the vram split transfer and nibble control block
package vst_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register byte offsets on the apb bus
   localparam logic [7:0] GCR_OFF  = 8'h00;
   localparam logic [7:0] MUX_OFF  = 8'h04;
   localparam logic [7:0] STAT_OFF = 8'h08;
   localparam logic [7:0] CNT_OFF  = 8'h0c;

   ////////////////////////////////////////////////////////////////////////////
   // reset values and the pass-through code of the mux control field
   localparam logic [7:0] GCR_RST   = 8'h03;
   localparam logic [5:0] MUX_RST   = 6'h2d;
   localparam logic [5:0] PASS_CODE = 6'h2d;

   ////////////////////////////////////////////////////////////////////////////
   // general control field positions
   localparam int GCR_HPOL  = 0;
   localparam int GCR_VPOL  = 1;
   localparam int GCR_SPLIT = 2;
   localparam int GCR_NIB   = 3;
   localparam int GCR_PED   = 4;
   localparam int GCR_GSYNC = 5;
   localparam int GCR_BIGE  = 6;
   localparam int GCR_SEL   = 7;

   ////////////////////////////////////////////////////////////////////////////
   // status field positions
   localparam int ST_PASS   = 0;
   localparam int ST_SPLIT  = 1;
   localparam int ST_NIB    = 2;
   localparam int ST_FLAG   = 3;
   localparam int ST_BUSY   = 4;
   localparam int ST_CONFL  = 5;

   ////////////////////////////////////////////////////////////////////////////
   // inserted shift clock pulse timing
   localparam int CLK_PERIOD_PS     = 8000;
   localparam int PULSE_DLY_MAX_NS  = 20;
   localparam int PULSE_HIGH_MIN_NS = 15;
   localparam int PULSE_DLY_CYC  = (PULSE_DLY_MAX_NS * 1000) / CLK_PERIOD_PS;
   localparam int PULSE_HIGH_CYC =
      (PULSE_HIGH_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [2:0] PULSE_HIGH_CNT = 3'(PULSE_HIGH_CYC);

   typedef enum logic [1:0] {
      VST_IDLE = 2'b00,
      VST_HIGH = 2'b01,
      VST_HOLD = 2'b11
   } vst_pulse_e;

endpackage

// ==== hdl/vst_pulse_gen.sv ====
// extra shift clock pulse generator driven by the transfer flag edge
`timescale 1ns/1ps
module vst_pulse_gen (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic clear,
   input  wire logic enable,
   input  wire logic flag,
   output logic      pulse,
   output logic      start,
   output logic      busy
);

   vst_pkg::vst_pulse_e state_ff;
   vst_pkg::vst_pulse_e nxt_state;
   logic [2:0]          cnt_ff;
   logic                flag_prev_ff;

   ////////////////////////////////////////////////////////////////////////////
   // edge detect: a level held high never fires twice
   assign start = enable & flag & ~flag_prev_ff & (state_ff == vst_pkg::VST_IDLE);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_prev_ff <= 1'b0;
      end else begin
         flag_prev_ff <= flag;
      end
   end

   // state walk: idle, high for the minimum width, then hold until flag drops
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         vst_pkg::VST_IDLE: begin
            if (start) begin
               nxt_state = vst_pkg::VST_HIGH;
            end
         end
         vst_pkg::VST_HIGH: begin
            if (cnt_ff == 3'h1) begin
               nxt_state = flag ? vst_pkg::VST_HOLD : vst_pkg::VST_IDLE;
            end
         end
         vst_pkg::VST_HOLD: begin
            if (!flag) begin
               nxt_state = vst_pkg::VST_IDLE;
            end
         end
         default: nxt_state = vst_pkg::VST_IDLE;
      endcase
   end

   // soft reset also restarts the shift clock logic
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= vst_pkg::VST_IDLE;
      end else if (clear) begin
         state_ff <= vst_pkg::VST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // width counter loaded on the edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= 3'h0;
      end else if (clear) begin
         cnt_ff <= 3'h0;
      end else if (start) begin
         cnt_ff <= vst_pkg::PULSE_HIGH_CNT;
      end else if (cnt_ff != 3'h0) begin
         cnt_ff <= cnt_ff - 3'h1;
      end
   end

   assign pulse = (state_ff == vst_pkg::VST_HIGH);
   assign busy  = (state_ff != vst_pkg::VST_IDLE);

endmodule

// ==== hdl/vst_nibble_sel.sv ====
// pixel input latch and nibble selecting pipeline stage
`timescale 1ns/1ps
module vst_nibble_sel (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        load,
   input  wire logic        nibble_en,
   input  wire logic        upper_sel,
   input  wire logic        big_endian,
   input  wire logic [31:0] pixel_in,
   output logic      [31:0] pixel_out,
   output logic             pixel_valid
);

   logic [31:0] latch_ff;
   logic        latch_vld_ff;
   logic [31:0] nxt_pipe;
   logic [31:0] pipe_ff;
   logic        pipe_vld_ff;

   ////////////////////////////////////////////////////////////////////////////
   // full bytes are always latched, even in nibble mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_ff     <= 32'h0000_0000;
         latch_vld_ff <= 1'b0;
      end else begin
         latch_vld_ff <= load;
         if (load) begin
            latch_ff <= pixel_in;
         end
      end
   end

   // per byte: order swap, then nibble pick into the low four bits
   genvar b;
   generate
      for (b = 0; b < 4; b++) begin : g_byte
         logic [7:0] src;
         assign src = big_endian ? latch_ff[8*(3-b) +: 8] : latch_ff[8*b +: 8];
         // flag is used live, not latched, so it must only move in blanking
         assign nxt_pipe[8*b +: 8] = !nibble_en ? src :
                                     upper_sel  ? {4'h0, src[7:4]} :
                                                  {4'h0, src[3:0]};
      end
   endgenerate

   // next pipeline register after the latch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pipe_ff     <= 32'h0000_0000;
         pipe_vld_ff <= 1'b0;
      end else begin
         pipe_vld_ff <= latch_vld_ff;
         if (latch_vld_ff) begin
            pipe_ff <= nxt_pipe;
         end
      end
   end

   assign pixel_out   = pipe_ff;
   assign pixel_valid = pipe_vld_ff;

endmodule

// ==== hdl/vst_ctrl.sv ====
// frame buffer control: shift clock insertion, nibble mode, syncs, registers
//
// Functional notes
// - split enable set, nibble clear: each flag rise adds one shift clock pulse.
// - inserted pulse starts within 20 ns of the flag rising edge.
// - inserted pulse stays high at least 15 ns.
// - split enabled with flag low leaves the shift clock untouched.
// - nibble mode builds a 16-bit bus from one nibble of each byte.
// - flag high picks upper nibbles, flag low picks lower nibbles.
// - nibble selection works in any mux mode, shift clock ratio unchanged.
// - full bytes latched, chosen nibble in low four bits, high bits zero.
// - both enables clear: flag input only shows in status bit 3.
// - select output low at reset and in pass-through, else control bit 7.
// - control bit 0 sets horizontal sync polarity, high by default.
// - control bit 1 sets vertical sync polarity, high by default.
// - polarity applies in normal modes; pass-through syncs pass unchanged.
// - control bit 4 picks the blanking pedestal, 0 IRE by default.
// - control bit 5 enables sync on the green output.
// - control bit 6 picks pixel byte order, little-endian by default.
// - control bit 7 only drives the select output level.
// - writing the pass-through code to mux control is a soft reset.
`timescale 1ns/1ps
module vst_ctrl (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        transfer_nibble_flag,
   input  wire logic        shift_clock_base,
   input  wire logic        pixel_load,
   input  wire logic [31:0] pixel_in,
   input  wire logic        hsync_n_in,
   input  wire logic        vsync_n_in,
   output logic             shift_clock_out,
   output logic      [31:0] pixel_out,
   output logic             pixel_out_valid,
   output logic             horizontal_sync_out,
   output logic             vertical_sync_out,
   output logic             sync_source_select_out,
   output logic             pedestal_enable,
   output logic             green_sync_enable,
   output logic             big_endian_mode,
   output logic             pass_through_mode
);

   logic [7:0]  gcr_ff;
   logic [5:0]  mux_ff;
   logic [31:0] prdata_ff;
   logic [15:0] pulse_cnt_ff;
   logic        sclk_out_ff;
   logic        hsync_ff;
   logic        vsync_ff;
   logic        sel_out_ff;
   logic        setup_ph;
   logic        access_ph;
   logic        wr_en;
   logic        addr_hit;
   logic        soft_reset;
   logic        pass_mode;
   logic        split_act;
   logic        nibble_act;
   logic        conflict;
   logic        ins_pulse;
   logic        ins_start;
   logic        ins_busy;
   logic [7:0]  status;

   ////////////////////////////////////////////////////////////////////////////
   // decode helpers

   // true for the byte offsets that hold a register
   function automatic logic reg_hit(input logic [7:0] a);
      reg_hit = (a == vst_pkg::GCR_OFF) || (a == vst_pkg::MUX_OFF) ||
                (a == vst_pkg::STAT_OFF) || (a == vst_pkg::CNT_OFF);
   endfunction

   // pass-through is the one mux field code that also means reset state
   function automatic logic is_pass(input logic [5:0] m);
      is_pass = (m == vst_pkg::PASS_CODE);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // apb phases; the slave never inserts wait states

   assign setup_ph  = psel & ~penable;
   assign access_ph = psel & penable;
   assign wr_en     = access_ph & pwrite;
   assign addr_hit  = reg_hit(paddr);
   assign pready    = 1'b1;
   assign pslverr   = access_ph & ~addr_hit; // unmapped or unaligned address

   // a write of the pass-through code restores every default
   assign soft_reset = wr_en & pstrb[0] & (paddr == vst_pkg::MUX_OFF) &
                       is_pass(pwdata[5:0]);

   ////////////////////////////////////////////////////////////////////////////
   // mode decode from the mux field and the two enables

   assign pass_mode = is_pass(mux_ff);
   // both enables set is illegal; we park both features rather than guess
   assign conflict   = gcr_ff[vst_pkg::GCR_SPLIT] & gcr_ff[vst_pkg::GCR_NIB];
   assign split_act  = gcr_ff[vst_pkg::GCR_SPLIT] & ~gcr_ff[vst_pkg::GCR_NIB];
   // no mux field term here: nibble pick ignores the mux setting
   assign nibble_act = gcr_ff[vst_pkg::GCR_NIB] & ~gcr_ff[vst_pkg::GCR_SPLIT];
   // with both clear, neither consumer of the flag is enabled

   ////////////////////////////////////////////////////////////////////////////
   // general control register

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gcr_ff <= vst_pkg::GCR_RST;
      end else if (soft_reset) begin
         gcr_ff <= vst_pkg::GCR_RST;
      end else if (wr_en && pstrb[0] && paddr == vst_pkg::GCR_OFF) begin
         gcr_ff <= pwdata[7:0];
      end
   end

   // mux control field; only the low six bits are kept
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mux_ff <= vst_pkg::MUX_RST;
      end else if (wr_en && pstrb[0] && paddr == vst_pkg::MUX_OFF) begin
         mux_ff <= pwdata[5:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // inserted pulse counter; a pulse in the clearing cycle still counts

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulse_cnt_ff <= 16'h0000;
      end else if (soft_reset) begin
         pulse_cnt_ff <= 16'h0000;
      end else if (ins_start) begin
         if (wr_en && paddr == vst_pkg::CNT_OFF) begin
            pulse_cnt_ff <= 16'h0001;
         end else begin
            pulse_cnt_ff <= pulse_cnt_ff + 16'h0001;
         end
      end else if (wr_en && paddr == vst_pkg::CNT_OFF) begin
         pulse_cnt_ff <= 16'h0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status and read data, captured in the setup cycle

   always_comb begin
      status                  = 8'h00;
      status[vst_pkg::ST_PASS]  = pass_mode;
      status[vst_pkg::ST_SPLIT] = split_act;
      status[vst_pkg::ST_NIB]   = nibble_act;
      status[vst_pkg::ST_FLAG]  = transfer_nibble_flag;
      status[vst_pkg::ST_BUSY]  = ins_busy;
      status[vst_pkg::ST_CONFL] = conflict;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h0000_0000;
      end else if (setup_ph && !pwrite) begin
         case (paddr)
            vst_pkg::GCR_OFF:  prdata_ff <= {24'h00_0000, gcr_ff};
            vst_pkg::MUX_OFF:  prdata_ff <= {26'h000_0000, mux_ff};
            vst_pkg::STAT_OFF: prdata_ff <= {24'h00_0000, status};
            vst_pkg::CNT_OFF:  prdata_ff <= {16'h0000, pulse_cnt_ff};
            default:           prdata_ff <= 32'h0000_0000;
         endcase
      end
   end

   assign prdata = prdata_ff;

   ////////////////////////////////////////////////////////////////////////////
   // extra shift clock pulse for split transfers

   vst_pulse_gen u_pulse (
      .pclk    (pclk),
      .presetn (presetn),
      .clear   (soft_reset),
      .enable  (split_act),
      .flag    (transfer_nibble_flag),
      .pulse   (ins_pulse),
      .start   (ins_start),
      .busy    (ins_busy)
   );

   // the pulse is ored into the divided shift clock, whose ratio stays as set
   // outside; with flag low the output is the base clock one stage later
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_out_ff <= 1'b0;
      end else begin
         sclk_out_ff <= shift_clock_base | ins_pulse;
      end
   end

   assign shift_clock_out = sclk_out_ff;

   ////////////////////////////////////////////////////////////////////////////
   // pixel latch and nibble selection

   vst_nibble_sel u_nibble (
      .pclk        (pclk),
      .presetn     (presetn),
      .load        (pixel_load),
      .nibble_en   (nibble_act),
      .upper_sel   (transfer_nibble_flag),
      .big_endian  (gcr_ff[vst_pkg::GCR_BIGE]),
      .pixel_in    (pixel_in),
      .pixel_out   (pixel_out),
      .pixel_valid (pixel_out_valid)
   );

   ////////////////////////////////////////////////////////////////////////////
   // sync outputs: incoming syncs are active low in normal modes

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hsync_ff <= 1'b0;
         vsync_ff <= 1'b0;
      end else if (pass_mode) begin
         hsync_ff <= hsync_n_in;
         vsync_ff <= vsync_n_in;
      end else begin
         hsync_ff <= gcr_ff[vst_pkg::GCR_HPOL] ? ~hsync_n_in : hsync_n_in;
         vsync_ff <= gcr_ff[vst_pkg::GCR_VPOL] ? ~vsync_n_in : vsync_n_in;
      end
   end

   assign horizontal_sync_out = hsync_ff;
   assign vertical_sync_out   = vsync_ff;

   ////////////////////////////////////////////////////////////////////////////
   // select output; bit 7 feeds nothing else inside the block

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_out_ff <= 1'b0;
      end else begin
         sel_out_ff <= ~pass_mode & gcr_ff[vst_pkg::GCR_SEL];
      end
   end

   assign sync_source_select_out = sel_out_ff;

   ////////////////////////////////////////////////////////////////////////////
   // analog side controls, straight from the register

   assign pedestal_enable   = gcr_ff[vst_pkg::GCR_PED];
   assign green_sync_enable = gcr_ff[vst_pkg::GCR_GSYNC];
   assign big_endian_mode   = gcr_ff[vst_pkg::GCR_BIGE];
   assign pass_through_mode = pass_mode;

endmodule

// ==== test/vst_checker.sv ====
// assertion checker for the vram split transfer and nibble control block
`timescale 1ns/1ps
module vst_checker (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        transfer_nibble_flag,
   input wire logic        shift_clock_base,
   input wire logic        pixel_load,
   input wire logic        hsync_n_in,
   input wire logic        vsync_n_in,
   input wire logic        shift_clock_out,
   input wire logic        pixel_out_valid,
   input wire logic        horizontal_sync_out,
   input wire logic        vertical_sync_out,
   input wire logic        sync_source_select_out,
   input wire logic        pedestal_enable,
   input wire logic        green_sync_enable,
   input wire logic        big_endian_mode,
   input wire logic        pass_through_mode
);
   logic [7:0] gcr_ff;
   logic       wr_ok;
   logic       sp;
   logic       sel_exp;
   logic [1:0] sync_exp;
   logic       mapped;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // control register shadow kept from bus writes, soft reset included
   assign wr_ok = psel && penable && pwrite && pstrb[0];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gcr_ff <= vst_pkg::GCR_RST;
      end else if (wr_ok && paddr == vst_pkg::GCR_OFF) begin
         gcr_ff <= pwdata[7:0];
      end else if (wr_ok && paddr == vst_pkg::MUX_OFF && pwdata[5:0] == vst_pkg::PASS_CODE) begin
         gcr_ff <= vst_pkg::GCR_RST;
      end
   end

   // expected levels; polarity bits count only outside pass-through
   assign sp       = gcr_ff[2] && !gcr_ff[3];
   assign sel_exp  = !pass_through_mode && gcr_ff[7];
   assign sync_exp = {vsync_n_in ^ (gcr_ff[1] && !pass_through_mode),
                      hsync_n_in ^ (gcr_ff[0] && !pass_through_mode)};
   assign mapped   = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c};

   ////////////////////////////////////////
   chk_split_pulse: assert property (
      sp && $rose(transfer_nibble_flag) && !$past(transfer_nibble_flag, 2)
      && !$past(transfer_nibble_flag, 3) |-> ##2 shift_clock_out [*2])
      else $error("inserted shift clock pulse missing or short");
   chk_flag_ignored: assert property (
      (!sp || !transfer_nibble_flag) [*4] |=> shift_clock_out == $past(shift_clock_base))
      else $error("shift clock differs from base clock");
   chk_one_pulse: assert property (
      (transfer_nibble_flag && !shift_clock_base) [*6] |-> !shift_clock_out)
      else $error("held flag gave more than one pulse");
   chk_select_out: assert property (
      presetn |=> sync_source_select_out == $past(sel_exp))
      else $error("select output level wrong");
   chk_sync_polarity: assert property (
      presetn |=> {vertical_sync_out, horizontal_sync_out} == $past(sync_exp))
      else $error("sync output polarity wrong");
   chk_ctrl_bits: assert property (
      {big_endian_mode, green_sync_enable, pedestal_enable} == gcr_ff[6:4])
      else $error("control bit outputs wrong");
   chk_pixel_pipe: assert property (
      1'b1 |-> ##2 pixel_out_valid == $past(pixel_load, 2))
      else $error("pixel valid not two cycles after load");
   chk_apb_answer: assert property (
      psel && penable |-> pready && pslverr == !mapped)
      else $error("bus answer wrong");
endmodule

bind vst_ctrl vst_checker vst_checker_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pstrb, .pready, .pslverr, .transfer_nibble_flag, .shift_clock_base, .pixel_load,
   .hsync_n_in, .vsync_n_in, .shift_clock_out, .pixel_out_valid, .horizontal_sync_out,
   .vertical_sync_out, .sync_source_select_out, .pedestal_enable, .green_sync_enable,
   .big_endian_mode, .pass_through_mode);

// ==== test/vst_vram_model.sv ====
// vram serial port with external flag and blanking logic
`timescale 1ns/1ps
module vst_vram_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        run,
   input  wire logic        split_req,
   input  wire logic        nib_lvl,
   input  wire logic [31:0] data,
   output logic             shift_clock_base,
   output logic             pixel_load,
   output logic      [31:0] pixel_in,
   output logic             transfer_nibble_flag
);
   logic [3:0] pos_ff;
   logic       in_blank;
   logic       req_ff;
   logic       latch_ff;
   logic       nib_ff;

   // line of twelve active cycles then four blanking cycles
   assign in_blank = pos_ff >= 4'hb && pos_ff < 4'hf;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pos_ff   <= 4'h0;
         req_ff   <= 1'b0;
         latch_ff <= 1'b0;
         nib_ff   <= 1'b0;
      end else begin
         pos_ff   <= pos_ff + 4'h1;
         req_ff   <= split_req || (req_ff && !in_blank);
         latch_ff <= in_blank && (latch_ff || req_ff);
         if (in_blank) begin
            nib_ff <= nib_lvl;
         end
      end
   end

   // data shows only in the load cycle, its inverse otherwise
   assign shift_clock_base     = run && pos_ff < 4'hc && pos_ff[0];
   assign pixel_load           = run && pos_ff < 4'hc && pos_ff[1:0] == 2'b01;
   assign pixel_in             = pixel_load ? data : ~data;
   assign transfer_nibble_flag = latch_ff || nib_ff;
endmodule

// ==== test/tb_top.sv ====
// self-checking bench for the vram split transfer and nibble control block
`timescale 1ns/1ps
module tb_top;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0]  paddr, gcr_m;
   logic [31:0] pwdata, prdata, pixel_in, pixel_out, data, rd, lat, exp_px;
   logic [3:0]  pstrb;
   logic        transfer_nibble_flag, shift_clock_base, pixel_load, pixel_out_valid;
   logic        hsync_n_in, vsync_n_in, shift_clock_out, pass_through_mode;
   logic        run, split_req, nib_lvl, base_d, fl_d;
   logic [1:0]  pv;
   int          seed, num_errors, checks_done, cyc, s, i;

   vst_ctrl vst_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .transfer_nibble_flag, .shift_clock_base, .pixel_load,
      .pixel_in, .hsync_n_in, .vsync_n_in, .shift_clock_out, .pixel_out, .pixel_out_valid,
      .horizontal_sync_out(), .vertical_sync_out(), .sync_source_select_out(),
      .pedestal_enable(), .green_sync_enable(), .big_endian_mode(), .pass_through_mode);
   vst_vram_model vst_vram_model_i (.pclk, .presetn, .run, .split_req, .nib_lvl, .data,
      .shift_clock_base, .pixel_load, .pixel_in, .transfer_nibble_flag);

   always #4 pclk = ~pclk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic give_verdict;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // one bus transfer, held until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] st);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= st;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, 4'hf);
      chk(rd, e);
   endtask

   // nibble and byte order reference, flag taken live
   function automatic logic [31:0] nib(input logic [31:0] v, input logic f);
      logic [31:0] r;
      for (int b = 0; b < 4; b++) begin
         r[8*b +: 8] = gcr_m[6] ? v[8*(3-b) +: 8] : v[8*b +: 8];
         if (gcr_m[3] && !gcr_m[2]) r[8*b +: 8] = {4'h0, f ? r[8*b+4 +: 4] : r[8*b +: 4]};
      end
      return r;
   endfunction

   // reference model, compared at every edge out of reset; also random syncs and data
   always @(posedge pclk) begin
      {hsync_n_in, vsync_n_in} <= 2'($random(seed));
      data <= $random(seed);
      cyc++;
      if (cyc > 6000) begin
         num_errors++;
         give_verdict;
      end
      if (!presetn) begin
         gcr_m = 8'h03;
         s = 0;
         pv = 2'b00;
         base_d = 1'b0;
      end else begin
         chk(shift_clock_out, base_d | s[0]);
         chk(pixel_out_valid, pv[1]);
         if (pv[1]) chk(pixel_out, exp_px);
         s = s >> 1;
         if (gcr_m[2] && !gcr_m[3] && transfer_nibble_flag && !fl_d) s = 6;
         if (pv[0]) exp_px = nib(lat, transfer_nibble_flag);
         pv = {pv[0], pixel_load};
         if (pixel_load) lat = pixel_in;
         if (psel && penable && pwrite && pstrb[0]) begin
            if (paddr == 8'h00) gcr_m = pwdata[7:0];
            if (paddr == 8'h04 && pwdata[5:0] == 6'h2d) gcr_m = 8'h03;
         end
      end
      base_d = shift_clock_base;
      fl_d = transfer_nibble_flag;
   end

   initial begin
      seed = 42737;
      {pclk, presetn, psel, penable, pwrite, run, split_req, nib_lvl} = 8'h00;
      {paddr, pwdata, pstrb, data, hsync_n_in, vsync_n_in} = '0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rchk(8'h00, 32'h03);
      rchk(8'h04, 32'h2d);
      chk(pass_through_mode, 1'b1);
      apb(1'b1, 8'h10, 32'hff, 4'hf);
      chk(er, 1'b1);
      apb(1'b1, 8'h08, 32'hff, 4'hf);
      chk(er, 1'b0);
      apb(1'b1, 8'h04, 32'h0, 4'hf);
      for (i = 0; i < 16; i++) begin
         pwdata <= 32'($random(seed)) & 32'hf3;
         @(posedge pclk);
         apb(1'b1, 8'h00, pwdata, 4'hf);
         rchk(8'h00, gcr_m);
      end
      apb(1'b1, 8'h00, 32'h80, 4'h0);
      rchk(8'h00, gcr_m);
      run <= 1'b1;
      apb(1'b1, 8'h00, 32'h04, 4'hf);
      rchk(8'h08, 32'h02);
      repeat (6) begin
         split_req <= 1'b1;
         @(posedge pclk);
         split_req <= 1'b0;
         repeat (31) @(posedge pclk);
      end
      run <= 1'b0;
      nib_lvl <= 1'b1;
      repeat (40) @(posedge pclk);
      nib_lvl <= 1'b0;
      repeat (20) @(posedge pclk);
      rchk(8'h0c, 32'h7);
      apb(1'b1, 8'h0c, 32'h0, 4'hf);
      rchk(8'h0c, 32'h0);
      run <= 1'b1;
      for (i = 0; i < 5; i++) begin
         apb(1'b1, 8'h04, 32'(i), 4'hf);
         apb(1'b1, 8'h00, i[0] ? 32'h48 : (i == 4 ? 32'h41 : 32'h08), 4'hf);
         repeat (6) begin
            nib_lvl <= 1'($random(seed));
            split_req <= (i == 4);
            repeat (16) @(posedge pclk);
         end
         split_req <= 1'b0;
      end
      nib_lvl <= 1'b0;
      apb(1'b1, 8'h00, 32'h80, 4'hf);
      apb(1'b1, 8'h04, 32'h2d, 4'hf);
      rchk(8'h00, 32'h03);
      chk(pass_through_mode, 1'b1);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rchk(8'h0c, 32'h0);
      give_verdict;
   end
endmodule
